// [ffa_map.vh]
// fault flag aggregator: register offsets, field positions, reset values, timing
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef FFA_MAP_VH
`define FFA_MAP_VH

`define FFA_ADDR_W        8
`define FFA_REG_LIVE      8'h00
`define FFA_REG_LATCH     8'h04
`define FFA_REG_MASK      8'h08
`define FFA_REG_SHUT_EN   8'h0c
`define FFA_REG_ECC_CORR  8'h10
`define FFA_REG_ECC_ERR   8'h14
`define FFA_REG_NVM_DET   8'h18

`define FFA_NSRC          18
`define FFA_NLAT          20
`define FFA_NMASK         19

`define FFA_SRC_IO_GOOD   0
`define FFA_SRC_LDO_UV    1
`define FFA_SRC_BUCK_OV   4
`define FFA_SRC_HC        10
`define FFA_SRC_BAT_GOOD  11
`define FFA_SRC_REF_UV    12
`define FFA_SRC_IN_UVPD   13
`define FFA_SRC_FRST      14
`define FFA_SRC_WDOG      15
`define FFA_SRC_OT_SHUT   16
`define FFA_SRC_OT_WARN   17
`define FFA_LAT_NVM_FAULT 18
`define FFA_LAT_READ_OK   19

`define FFA_LONG_SET      18'h013ff
`define FFA_SHORT_SET     18'h02c00
`define FFA_SHUT_CFG_SET  18'h013fe
`define FFA_SHUT_FIX_SET  18'h12000

`define FFA_MASK_RESET    19'h00000
`define FFA_SHUT_RESET    18'h00000

`define FFA_CLK_MHZ       100
`define FFA_DEG_LONG_US   1000
`define FFA_DEG_SHORT_US  100

`define FFA_RESP_OKAY     2'b00
`define FFA_RESP_SLVERR   2'b10

`endif

// [ffa_top.v]
// fault flag aggregator: live, deglitched and latched fault flags, interrupt and power-off
// assumes fault pins are asynchronous and nvm event pulses come from logic on aclk
// deglitch sets, fixed power-off sources and register offsets come from ffa_map.vh
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ffa_map.vh"

module ffa_top #(
  parameter integer DEG_LONG  = `FFA_DEG_LONG_US * `FFA_CLK_MHZ,
  parameter integer DEG_SHORT = `FFA_DEG_SHORT_US * `FFA_CLK_MHZ,
  parameter integer CNT_W     = 17
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        io_supply_good,
  input  wire [2:0]  ldo_undervoltage,
  input  wire [5:0]  buck_overvoltage,
  input  wire        rail1_high_current,
  input  wire        backup_battery_good,
  input  wire        reference_input_undervoltage,
  input  wire        input_undervoltage_powerdown,
  input  wire        forced_reset_event,
  input  wire        watchdog_fault,
  input  wire        thermal_shutdown,
  input  wire        thermal_warning,
  input  wire        rail2_softstart_done,
  input  wire        nvm_fault,
  input  wire        ok_a,
  input  wire [7:0]  ecc_corrected,
  input  wire [7:0]  ecc_uncorrectable,
  input  wire        nvm_data_valid,
  input  wire        nvm_fault_flag,
  output wire        irq_n_out,
  output wire        irq_n_oe,
  output reg         power_off_request
);

  localparam [`FFA_NSRC-1:0] LONG_SET  = `FFA_LONG_SET;
  localparam [`FFA_NSRC-1:0] SHORT_SET = `FFA_SHORT_SET;
  localparam [`FFA_NSRC-1:0] SHUT_CFG  = `FFA_SHUT_CFG_SET;
  localparam [`FFA_NSRC-1:0] SHUT_FIX  = `FFA_SHUT_FIX_SET;
  localparam [CNT_W-1:0]     N_LONG    = DEG_LONG[CNT_W-1:0];
  localparam [CNT_W-1:0]     N_SHORT   = DEG_SHORT[CNT_W-1:0];
  localparam [CNT_W-1:0]     N_NONE    = {CNT_W{1'b0}};

  // fault conditions plus rail-2 soft-start done on the top bit, high when present; good monitors are inverted
  wire [`FFA_NSRC:0] pin_raw = {rail2_softstart_done, thermal_warning, thermal_shutdown,
                                watchdog_fault, forced_reset_event,
                                input_undervoltage_powerdown, reference_input_undervoltage,
                                ~backup_battery_good, rail1_high_current, buck_overvoltage,
                                ldo_undervoltage, ~io_supply_good};

  // three-stage synchroniser; a change counts once stages two and three agree
  reg [`FFA_NSRC:0] sync1;
  reg [`FFA_NSRC:0] sync2;
  reg [`FFA_NSRC:0] sync3;
  reg [`FFA_NSRC:0] pin;
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= {(`FFA_NSRC+1){1'b0}};
      sync2 <= {(`FFA_NSRC+1){1'b0}};
      sync3 <= {(`FFA_NSRC+1){1'b0}};
      pin   <= {(`FFA_NSRC+1){1'b0}};
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pin   <= (sync2 & sync3) | (pin & (sync2 | sync3));
    end
  end

  wire [`FFA_NSRC-1:0] live = pin[`FFA_NSRC-1:0];
  wire                 rail2_done = pin[`FFA_NSRC];

  // deglitch per source
  wire [`FFA_NSRC-1:0] qual;
  genvar gi;
  generate
    for (gi = 0; gi < `FFA_NSRC; gi = gi + 1) begin : g_deg
      localparam [CNT_W-1:0] NEED = LONG_SET[gi] ? N_LONG : (SHORT_SET[gi] ? N_SHORT : N_NONE);
      wire             watch = live[gi] & ((gi != `FFA_SRC_REF_UV) | rail2_done);
      reg  [CNT_W-1:0] cnt;
      reg              q;
      always @(posedge aclk) begin
        if (!aresetn) begin
          cnt <= {CNT_W{1'b0}};
          q   <= 1'b0;
        end else if (!watch) begin
          cnt <= {CNT_W{1'b0}};
          q   <= 1'b0;
        end else begin
          if (cnt != NEED)
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          q <= (cnt == NEED);
        end
      end
      assign qual[gi] = q;
    end
  endgenerate

  // last deglitched warning, so the warning flag re-sets only on a new edge
  reg ot_warn_prev;
  always @(posedge aclk) begin
    if (!aresetn)
      ot_warn_prev <= 1'b0;
    else
      ot_warn_prev <= qual[`FFA_SRC_OT_WARN];
  end

  // set vectors; warning edge-set, all others level-set
  wire [`FFA_NLAT-1:0] lat_set = {ok_a, nvm_fault,
                                  qual[`FFA_SRC_OT_WARN] & ~ot_warn_prev,
                                  qual[`FFA_NSRC-2:0]};

  // axi4-lite slave
  reg        aw_held;
  reg        w_held;
  reg  [7:0] aw_addr;
  reg [31:0] w_data;
  reg  [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // true for an address that names one of the registers
  function ffa_mapped;
    input [7:0] addr;
    begin
      case ({addr[7:2], 2'b00})
        `FFA_REG_LIVE, `FFA_REG_LATCH, `FFA_REG_MASK, `FFA_REG_SHUT_EN,
        `FFA_REG_ECC_CORR, `FFA_REG_ECC_ERR, `FFA_REG_NVM_DET: ffa_mapped = 1'b1;
        default: ffa_mapped = 1'b0;
      endcase
    end
  endfunction

  wire        do_write = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;
  wire        wr_lat  = do_write && (aw_addr == `FFA_REG_LATCH);
  wire        wr_mask = do_write && (aw_addr == `FFA_REG_MASK);
  wire        wr_shut = do_write && (aw_addr == `FFA_REG_SHUT_EN);
  wire        wr_corr = do_write && (aw_addr == `FFA_REG_ECC_CORR);
  wire        wr_err  = do_write && (aw_addr == `FFA_REG_ECC_ERR);
  wire        wr_det  = do_write && (aw_addr == `FFA_REG_NVM_DET);
  wire        wr_hit  = ffa_mapped(aw_addr);

  reg [`FFA_NLAT-1:0]  latched;
  reg [`FFA_NMASK-1:0] mask;
  reg [`FFA_NSRC-1:0]  shut_en;
  reg [7:0]            ecc_corr_lat;
  reg [7:0]            ecc_err_lat;
  reg [1:0]            nvm_det_lat;

  // write-one-to-clear; a set in the same cycle wins
  wire [`FFA_NLAT-1:0] next_latched  = (latched & ~({`FFA_NLAT{wr_lat}} & wbits[`FFA_NLAT-1:0]))
                                       | lat_set;
  wire [7:0]           next_ecc_corr = (ecc_corr_lat & ~({8{wr_corr}} & wbits[7:0]))
                                       | ecc_corrected;
  wire [7:0]           next_ecc_err  = (ecc_err_lat & ~({8{wr_err}} & wbits[7:0]))
                                       | ecc_uncorrectable;
  wire [1:0]           next_nvm_det  = (nvm_det_lat & ~({2{wr_det}} & wbits[1:0]))
                                       | {nvm_fault_flag, nvm_data_valid};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FFA_RESP_OKAY;
      latched      <= {`FFA_NLAT{1'b0}};
      mask         <= `FFA_MASK_RESET;
      shut_en      <= `FFA_SHUT_RESET;
      ecc_corr_lat <= 8'h00;
      ecc_err_lat  <= 8'h00;
      nvm_det_lat  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `FFA_RESP_OKAY : `FFA_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      latched      <= next_latched;
      ecc_corr_lat <= next_ecc_corr;
      ecc_err_lat  <= next_ecc_err;
      nvm_det_lat  <= next_nvm_det;
      // read-write registers honour the byte strobes
      if (wr_mask)
        mask <= (mask & ~wmask[`FFA_NMASK-1:0]) | wbits[`FFA_NMASK-1:0];
      if (wr_shut)
        shut_en <= ((shut_en & ~wmask[`FFA_NSRC-1:0]) | wbits[`FFA_NSRC-1:0]) & SHUT_CFG;
    end
  end

  // read channel, answer one cycle after the address is taken
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_hit = ffa_mapped(s_axi_araddr);
    case ({s_axi_araddr[7:2], 2'b00})
      `FFA_REG_LIVE:     rd_mux = {{(32-`FFA_NSRC){1'b0}}, live};
      `FFA_REG_LATCH:    rd_mux = {{(32-`FFA_NLAT){1'b0}}, latched};
      `FFA_REG_MASK:     rd_mux = {{(32-`FFA_NMASK){1'b0}}, mask};
      `FFA_REG_SHUT_EN:  rd_mux = {{(32-`FFA_NSRC){1'b0}}, shut_en};
      `FFA_REG_ECC_CORR: rd_mux = {24'h000000, ecc_corr_lat};
      `FFA_REG_ECC_ERR:  rd_mux = {24'h000000, ecc_err_lat};
      `FFA_REG_NVM_DET:  rd_mux = {30'h0, nvm_det_lat};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  // read data stands until the host takes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FFA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `FFA_RESP_OKAY : `FFA_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // open-drain interrupt: pulled low while any unmasked latched flag in bits 0 to 18 is set
  reg  irq_active;
  // interrupt and power-off levels, registered below
  wire next_irq_active = |(latched[`FFA_NMASK-1:0] & ~mask);
  wire next_power_off  = |(latched[`FFA_NSRC-1:0] & (shut_en | SHUT_FIX));

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_active        <= 1'b0;
      power_off_request <= 1'b0;
    end else begin
      irq_active        <= next_irq_active;
      power_off_request <= next_power_off;
    end
  end
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = irq_active;

  wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, s_axi_araddr[1:0], s_axi_awaddr[1:0]};

endmodule
`default_nettype wire

// [ffa_host_pin.sv]
// host side of the interrupt pin: open-drain wire with a pull-up
// assumes the device pulls the wire while irq_n_oe is high
`timescale 1ns/1ps
`default_nettype none
module ffa_host_pin (
  input  wire logic irq_n_out,
  input  wire logic irq_n_oe,
  output wire logic irq_n
);
  // released wire floats to the pull-up level
  assign irq_n = irq_n_oe ? irq_n_out : 1'b1;
endmodule
`default_nettype wire

// [ffa_top_assertions.sv]
// checker for ffa_top: bus answers, interrupt pin and power-off relations
// assumes one clock aclk and synchronous active-low reset aresetn
`timescale 1ns/1ps
`default_nettype none
module ffa_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        thermal_shutdown,
  input wire logic        irq_n_out,
  input wire logic        irq_n_oe,
  input wire logic        power_off_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_irq_drain_low: assert property (irq_n_oe |-> !irq_n_out)
    else $error("interrupt pin driven high");
  a_irq_release: assert property ($fell(irq_n_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt released without a write");
  a_power_release: assert property ($fell(power_off_request) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("power-off released without a write");
  a_thermal_off: assert property (thermal_shutdown [*8] |-> ##[0:4] power_off_request)
    else $error("thermal shutdown gave no power-off");
endmodule
bind ffa_top ffa_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .thermal_shutdown(thermal_shutdown), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .power_off_request(power_off_request));
`default_nettype wire

// [fault_flag_aggregator_tb_top.sv]
// testbench for ffa_top: register accesses over axi4-lite with fault pins
// assumes short deglitch counts and the host pin model on the interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ffa_map.vh"
module fault_flag_aggregator_tb_top;
  localparam integer      DL = 20;
  localparam integer      DS = 8;
  localparam logic [17:0] LS = `FFA_LONG_SET;
  localparam logic [17:0] SS = `FFA_SHORT_SET;
  localparam logic [17:0] FX = `FFA_SHUT_FIX_SET;
  localparam logic [17:0] SH = 18'h3f0aa & `FFA_SHUT_CFG_SET;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
  logic        arv = 1'b0, rr = 1'b0, rail = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, a;
  logic [31:0] wd = 32'h0, q, m;
  logic [17:0] flt = 18'h0;
  logic [19:0] nv = 20'h0;
  logic [1:0]  r;
  wire         awr, wrd, bv, arr, rv, irq_o, irq_e, poff, irq_n;
  wire  [1:0]  bp, rp;
  wire  [31:0] rdat;
  integer      err_count = 0, compares = 0, i, j, d;
  ffa_top #(.DEG_LONG(DL), .DEG_SHORT(DS)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rp), .s_axi_rvalid(rv), .s_axi_rready(rr), .io_supply_good(~flt[0]),
    .ldo_undervoltage(flt[3:1]), .buck_overvoltage(flt[9:4]), .rail1_high_current(flt[10]),
    .backup_battery_good(~flt[11]), .reference_input_undervoltage(flt[12]),
    .input_undervoltage_powerdown(flt[13]), .forced_reset_event(flt[14]),
    .watchdog_fault(flt[15]), .thermal_shutdown(flt[16]), .thermal_warning(flt[17]),
    .rail2_softstart_done(rail), .nvm_fault(nv[18]), .ok_a(nv[19]),
    .ecc_corrected(nv[7:0]), .ecc_uncorrectable(nv[15:8]), .nvm_data_valid(nv[16]),
    .nvm_fault_flag(nv[17]), .irq_n_out(irq_o), .irq_n_oe(irq_e), .power_off_request(poff));
  ffa_host_pin i_pin (.irq_n_out(irq_o), .irq_n_oe(irq_e), .irq_n(irq_n));
  always #5 aclk = ~aclk;
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input [7:0] ad, input [31:0] v);
    @(posedge aclk);
    awa <= ad;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    r = bp;
    br <= 1'b0;
  endtask
  task rc(input [7:0] ad, input [31:0] e);
    @(posedge aclk);
    ara <= ad;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    q = rdat;
    r = rp;
    rr <= 1'b0;
    chk(q, e);
    chk(r, ad == 8'h1c ? `FFA_RESP_SLVERR : `FFA_RESP_OKAY);
  endtask
  task end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    tick(5);
    aresetn <= 1'b1;
    for (a = 8'h00; a < 8'h20; a = a + 8'h04) rc(a, 0);
    wr(8'h1c, 0);
    chk(r, `FFA_RESP_SLVERR);
    flt <= 18'h01000;
    tick(40);
    rc(`FFA_REG_LATCH, 0);
    flt <= 18'h0;
    rail <= 1'b1;
    wr(`FFA_REG_SHUT_EN, 32'h3f0aa);
    rc(`FFA_REG_SHUT_EN, SH);
    for (i = 0; i < 18; i++) begin
      m = 32'h1 << i;
      d = LS[i] ? DL : (SS[i] ? DS : 0);
      if (d > 0) begin
        flt <= m[17:0];
        tick(d - 4);
        flt <= 18'h0;
        tick(12);
        rc(`FFA_REG_LATCH, 0);
      end
      flt <= m[17:0];
      tick(d + 12);
      rc(`FFA_REG_LIVE, m);
      rc(`FFA_REG_LATCH, m);
      chk(irq_n, 0);
      chk(poff, FX[i] | SH[i]);
      wr(`FFA_REG_LATCH, m);
      rc(`FFA_REG_LATCH, i == 17 ? 0 : m);
      flt <= 18'h0;
      tick(8);
      wr(`FFA_REG_LATCH, m);
      rc(`FFA_REG_LATCH, 0);
      chk(irq_n, 1);
      chk(poff, 0);
    end
    wr(`FFA_REG_MASK, 32'h7ffff);
    flt <= 18'h04000;
    tick(12);
    rc(`FFA_REG_LATCH, 32'h4000);
    chk(irq_n, 1);
    wr(`FFA_REG_MASK, 0);
    tick(2);
    chk(irq_n, 0);
    flt <= 18'h0;
    tick(8);
    wr(`FFA_REG_LATCH, 32'h4000);
    nv <= 20'hf3ca5;
    tick(1);
    nv <= 20'h0;
    rc(`FFA_REG_LATCH, 32'hc0000);
    chk(irq_n, 0);
    wr(`FFA_REG_LATCH, 32'hc0000);
    tick(2);
    chk(irq_n, 1);
    a = `FFA_REG_ECC_CORR;
    for (j = 0; j < 3; j++) begin
      m = j == 0 ? 32'ha5 : (j == 1 ? 32'h3c : 32'h3);
      rc(a, m);
      wr(a, 0);
      rc(a, m);
      wr(a, 1);
      rc(a, m & ~32'h1);
      wr(a, 32'hff);
      rc(a, 0);
      a = a + 8'h04;
    end
    end_sim;
  end
endmodule
`default_nettype wire
